// ==== include/pipc_pkg.sv ====
// Constants and types shared by the pin interrupt and priority controller
package pipc_pkg;
  // Register byte addresses on APB
  localparam logic [7:0] PIPC_ADDR_PIN_EN   = 8'h00;  // Pin interrupt enable
  localparam logic [7:0] PIPC_ADDR_BASE_PRI = 8'h04;  // Base priority and running flags
  localparam logic [7:0] PIPC_ADDR_EXT_PRI  = 8'h08;  // Extended priority and depth flag
  localparam logic [7:0] PIPC_ADDR_IRQ_EN   = 8'h0c;  // Global and base source enables
  localparam logic [7:0] PIPC_ADDR_EXT_EN   = 8'h10;  // Extended source enables
  localparam logic [7:0] PIPC_ADDR_REMAP    = 8'h14;  // Serial pin mapping selects
  localparam logic [7:0] PIPC_ADDR_STATUS   = 8'h18;  // Pin flag status, read only

  // Reset values
  localparam logic [7:0] PIPC_RST_BYTE  = 8'h00;  // Every software register resets to zero
  localparam logic [1:0] PIPC_RST_REMAP = 2'h0;   // Mapping selects reset value

  // Pin interrupt enable fields
  localparam int PIPC_PIN_EDGE_BIT  = 7;  // Edge versus level sensing
  localparam int PIPC_PIN_SER1_BIT  = 6;  // Serial 1 receive pin
  localparam int PIPC_PIN_P15_BIT   = 5;  // Port 1 pin 5
  localparam int PIPC_PIN_P14_BIT   = 4;  // Port 1 pin 4
  localparam int PIPC_PIN_P13_BIT   = 3;  // Port 1 pin 3
  localparam int PIPC_PIN_RST_BIT   = 2;  // Reset pin, active high
  localparam int PIPC_PIN_P31_BIT   = 1;  // Port 3 pin 1
  localparam int PIPC_PIN_SER0_BIT  = 0;  // Serial 0 receive pin
  localparam int PIPC_PIN_SRC_N     = 7;  // Number of pin sources

  // Priority and enable fields
  localparam int PIPC_HI_RUN_BIT    = 7;  // High level running flag
  localparam int PIPC_LO_RUN_BIT    = 6;  // Low level running flag
  localparam int PIPC_DEPTH_BIT     = 7;  // Nesting depth flag
  localparam int PIPC_ALLOW_BIT     = 7;  // Global allow
  localparam int PIPC_BLOCK_BIT     = 6;  // Global block
  localparam int PIPC_PIN_MASTER_BIT = 6; // Pin request enable in extended enables
  localparam int PIPC_BASE_SRC_N    = 6;  // Sources in the base registers

  // Interrupt numbering and vectors
  localparam int          PIPC_SRC_N      = 14;       // Interrupt sources
  localparam logic [3:0]  PIPC_PIN_IRQ_NO = 4'hc;     // Pin interrupt number
  localparam logic [15:0] PIPC_VEC_BASE   = 16'h0003; // First entry address
  localparam int          PIPC_VEC_SHIFT  = 3;        // Eight bytes per entry

  // Service level state
  typedef enum logic [1:0] {
    PIPC_RUN_IDLE,
    PIPC_RUN_LOW,
    PIPC_RUN_HIGH,
    PIPC_RUN_NESTED
  } pipc_run_t;
endpackage

// ==== hdl/pipc_ctrl.sv ====
// Pin interrupt sensing, two level priority arbitration and APB registers
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module pipc_ctrl
  import pipc_pkg::*;
(
  input  wire logic        ref_clk_i,       // System clock
  input  wire logic        rst_n_i,         // Asynchronous reset, active low
  input  wire logic        ce_i,            // Clock enable, freezes state when low
  input  wire logic        psel_i,          // APB select
  input  wire logic        penable_i,       // APB enable
  input  wire logic        pwrite_i,        // APB write
  input  wire logic [7:0]  paddr_i,         // APB byte address
  input  wire logic [31:0] pwdata_i,        // APB write data
  input  wire logic [3:0]  pstrb_i,         // APB byte strobes
  output logic      [31:0] prdata_o,        // APB read data
  output logic             pready_o,        // APB ready
  output logic             pslverr_o,       // APB error on unmapped address
  input  wire logic        ser1_rx_a_i,     // Serial 1 receive pin, default map
  input  wire logic        ser1_rx_b_i,     // Serial 1 receive pin, alternate map
  input  wire logic        port1_pin5_i,    // Port 1 pin 5
  input  wire logic        port1_pin4_i,    // Port 1 pin 4
  input  wire logic        port1_pin3_i,    // Port 1 pin 3
  input  wire logic        reset_pin_i,     // Reset pin level
  input  wire logic        port3_pin1_i,    // Port 3 pin 1
  input  wire logic        ser0_rx_a_i,     // Serial 0 receive pin, default map
  input  wire logic        ser0_rx_b_i,     // Serial 0 receive pin, alternate map
  input  wire logic [13:0] src_req_i,       // Peripheral requests; bit 12 unused
  input  wire logic        irq_ack_i,       // Core enters the offered routine
  input  wire logic        irq_ret_i,       // Core returns from a routine
  output logic             irq_req_o,       // Request to the core
  output logic      [3:0]  irq_num_o,       // Offered interrupt number
  output logic      [15:0] irq_vector_o,    // Offered entry address
  output logic             irq_high_o       // Offered request is high class
);

  // Software registers
  logic [7:0] pin_en_r;                     // Pin interrupt enable
  logic [5:0] base_pri_r;                   // Base priority bits
  logic [6:0] ext_pri_r;                    // Extended priority bits
  logic [7:0] irq_en_r;                     // Global and base enables
  logic [7:0] ext_en_r;                     // Extended enables
  logic [1:0] remap_r;                      // Serial pin mapping selects

  // Pin sensing state
  logic [PIPC_PIN_SRC_N-1:0] act_prev_r;    // Previous active conditions
  logic                      pin_flag_r;    // Pin interrupt active flag
  logic                      pin_flag_nxt;  // Next pin flag

  // Service state
  pipc_run_t run_r;                         // Running level
  pipc_run_t run_nxt;                       // Next running level

  // APB output registers
  logic [31:0] prdata_r;                    // Read data
  logic        pready_r;                    // Ready
  logic        pslverr_r;                   // Error

  // Core offer registers
  logic        irq_req_r;                   // Request
  logic [3:0]  irq_num_r;                   // Number
  logic [15:0] irq_vec_r;                   // Vector
  logic        irq_high_r;                  // Class

  // Selected serial receive pins
  wire logic ser1_rx = remap_r[1] ? ser1_rx_b_i : ser1_rx_a_i;
  wire logic ser0_rx = remap_r[0] ? ser0_rx_b_i : ser0_rx_a_i;

  // Active condition per pin, polarity normalised to high
  wire logic [PIPC_PIN_SRC_N-1:0] pin_act = {
    ~ser1_rx,
    ~port1_pin5_i,
    ~port1_pin4_i,
    ~port1_pin3_i,
    reset_pin_i,
    ~port3_pin1_i,
    ~ser0_rx
  };

  // Per pin enable mask, zero disables the source
  wire logic [PIPC_PIN_SRC_N-1:0] pin_mask = pin_en_r[PIPC_PIN_SRC_N-1:0];
  wire logic                      edge_mode = pin_en_r[PIPC_PIN_EDGE_BIT];

  // Level and edge conditions gathered into one term
  wire logic level_hit = |(pin_act & pin_mask);
  wire logic edge_hit  = |(pin_act & ~act_prev_r & pin_mask);

  // Entry into the pin routine clears the edge flag
  wire logic pin_entry = irq_ack_i & irq_req_r & (irq_num_r == PIPC_PIN_IRQ_NO);

  // Pin flag next value
  always_comb begin
    if (!edge_mode) begin
      pin_flag_nxt = level_hit;
    end else if (edge_hit) begin
      pin_flag_nxt = 1'b1;                  // Set wins over entry clear
    end else if (pin_entry) begin
      pin_flag_nxt = 1'b0;
    end else begin
      pin_flag_nxt = pin_flag_r;            // Holds until entry or a switch to level mode
    end
  end

  // Source vectors in interrupt number order
  wire logic [PIPC_SRC_N-1:0] src_en = {ext_en_r, irq_en_r[PIPC_BASE_SRC_N-1:0]};
  wire logic [PIPC_SRC_N-1:0] src_pri = {1'b0, ext_pri_r, base_pri_r};
  wire logic [PIPC_SRC_N-1:0] src_raw = {src_req_i[13], pin_flag_r, src_req_i[11:0]};
  wire logic [PIPC_SRC_N-1:0] pending = src_raw & src_en;
  wire logic [PIPC_SRC_N-1:0] pend_hi = pending & src_pri;
  wire logic [PIPC_SRC_N-1:0] pend_lo = pending & ~src_pri;
  wire logic                  allow   = irq_en_r[PIPC_ALLOW_BIT] &
                                        ~irq_en_r[PIPC_BLOCK_BIT];

  // Lowest set index wins
  function automatic logic [3:0] pipc_first(input logic [PIPC_SRC_N-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = PIPC_SRC_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Fixed order pick inside each class
  wire logic [3:0] hi_num = pipc_first(pend_hi);
  wire logic [3:0] lo_num = pipc_first(pend_lo);
  wire logic       any_hi = |pend_hi;
  wire logic       any_lo = |pend_lo;

  // Which class may be taken in the current running level
  wire logic take_hi = allow & any_hi & ((run_r == PIPC_RUN_IDLE) |
                                         (run_r == PIPC_RUN_LOW));
  wire logic take_lo = allow & any_lo & (run_r == PIPC_RUN_IDLE) & ~any_hi;
  wire logic [3:0] cand_num = take_hi ? hi_num : lo_num;
  wire logic [15:0] cand_vec = PIPC_VEC_BASE +
                               16'({12'h000, cand_num} << PIPC_VEC_SHIFT);

  // Running level sequencing on entry and return
  wire logic entry = irq_ack_i & irq_req_r;
  always_comb begin
    run_nxt = run_r;
    case (run_r)
      PIPC_RUN_IDLE: begin
        if (entry) begin
          run_nxt = irq_high_r ? PIPC_RUN_HIGH : PIPC_RUN_LOW;
        end
      end
      PIPC_RUN_LOW: begin
        if (entry) begin
          run_nxt = PIPC_RUN_NESTED;        // High preempts low
        end else if (irq_ret_i) begin
          run_nxt = PIPC_RUN_IDLE;
        end
      end
      PIPC_RUN_HIGH: begin
        if (irq_ret_i) begin
          run_nxt = PIPC_RUN_IDLE;
        end
      end
      PIPC_RUN_NESTED: begin
        if (irq_ret_i) begin
          run_nxt = PIPC_RUN_LOW;           // Resume the preempted low routine
        end
      end
      default: begin
        run_nxt = PIPC_RUN_IDLE;
      end
    endcase
  end

  // Read only status views
  wire logic hi_run = (run_r == PIPC_RUN_HIGH) | (run_r == PIPC_RUN_NESTED);
  wire logic lo_run = (run_r == PIPC_RUN_LOW);
  wire logic depth1 = (run_r == PIPC_RUN_LOW) | (run_r == PIPC_RUN_HIGH);

  // APB decode
  wire logic setup    = psel_i & ~penable_i;
  wire logic wr_done  = psel_i & penable_i & pready_r & pwrite_i & pstrb_i[0];
  wire logic hit_pin  = (paddr_i == PIPC_ADDR_PIN_EN);
  wire logic hit_bpri = (paddr_i == PIPC_ADDR_BASE_PRI);
  wire logic hit_epri = (paddr_i == PIPC_ADDR_EXT_PRI);
  wire logic hit_ien  = (paddr_i == PIPC_ADDR_IRQ_EN);
  wire logic hit_een  = (paddr_i == PIPC_ADDR_EXT_EN);
  wire logic hit_rmp  = (paddr_i == PIPC_ADDR_REMAP);
  wire logic hit_sts  = (paddr_i == PIPC_ADDR_STATUS);
  wire logic mapped   = hit_pin | hit_bpri | hit_epri | hit_ien | hit_een | hit_rmp | hit_sts;

  // Read data mux, low byte only
  wire logic [7:0] rd_byte =
    hit_pin  ? pin_en_r :
    hit_bpri ? {hi_run, lo_run, base_pri_r} :
    hit_epri ? {depth1, ext_pri_r} :
    hit_ien  ? irq_en_r :
    hit_een  ? ext_en_r :
    hit_rmp  ? {6'h00, remap_r} :
    hit_sts  ? {7'h00, pin_flag_r} : 8'h00;

  // APB response: ready one cycle after setup
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (ce_i) begin
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
      if (setup) begin
        prdata_r <= {24'h000000, rd_byte};
      end
    end
  end

  // Software register writes; status and flags ignore writes
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_en_r   <= PIPC_RST_BYTE;
      base_pri_r <= PIPC_RST_BYTE[5:0];
      ext_pri_r  <= PIPC_RST_BYTE[6:0];
      irq_en_r   <= PIPC_RST_BYTE;
      ext_en_r   <= PIPC_RST_BYTE;
      remap_r    <= PIPC_RST_REMAP;
    end else if (ce_i && wr_done) begin
      if (hit_pin) begin
        pin_en_r <= pwdata_i[7:0];
      end
      if (hit_bpri) begin
        base_pri_r <= pwdata_i[5:0];
      end
      if (hit_epri) begin
        ext_pri_r <= pwdata_i[6:0];
      end
      if (hit_ien) begin
        irq_en_r <= pwdata_i[7:0];
      end
      if (hit_een) begin
        ext_en_r <= pwdata_i[7:0];
      end
      if (hit_rmp) begin
        remap_r <= pwdata_i[1:0];
      end
    end
  end

  // Pin sensing and running level state
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_prev_r <= '0;
      pin_flag_r <= 1'b0;
      run_r      <= PIPC_RUN_IDLE;
    end else if (ce_i) begin
      act_prev_r <= pin_act;
      pin_flag_r <= pin_flag_nxt;
      run_r      <= run_nxt;
    end
  end

  // Offer to the core, withdrawn for one cycle after entry
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_req_r  <= 1'b0;
      irq_num_r  <= 4'h0;
      irq_vec_r  <= PIPC_VEC_BASE;
      irq_high_r <= 1'b0;
    end else if (ce_i) begin
      irq_req_r  <= (take_hi | take_lo) & ~entry;
      irq_num_r  <= cand_num;
      irq_vec_r  <= cand_vec;
      irq_high_r <= take_hi;
    end
  end

  // Outputs straight from flip-flops
  assign prdata_o     = prdata_r;
  assign pready_o     = pready_r;
  assign pslverr_o    = pslverr_r;
  assign irq_req_o    = irq_req_r;
  assign irq_num_o    = irq_num_r;
  assign irq_vector_o = irq_vec_r;
  assign irq_high_o   = irq_high_r;

endmodule

// ==== bench/pipc_asserts.sv ====
// Port-level checks for the pin interrupt and priority controller
`timescale 1ns/100ps
module pipc_asserts
  import pipc_pkg::*;
(
  input wire logic        ref_clk_i,     // System clock
  input wire logic        rst_n_i,       // Reset, active low
  input wire logic        psel_i,        // APB select
  input wire logic        penable_i,     // APB enable
  input wire logic        pwrite_i,      // APB write
  input wire logic [7:0]  paddr_i,       // APB address
  input wire logic [31:0] pwdata_i,      // APB write data
  input wire logic [3:0]  pstrb_i,       // APB strobes
  input wire logic [31:0] prdata_o,      // APB read data
  input wire logic        pready_o,      // APB ready
  input wire logic        pslverr_o,     // APB error
  input wire logic        irq_ack_i,     // Core entry
  input wire logic        irq_req_o,     // Request to core
  input wire logic [3:0]  irq_num_o,     // Offered number
  input wire logic [15:0] irq_vector_o,  // Offered entry address
  input wire logic        irq_high_o     // Offered class
);
  logic [7:0] en_sh;   // Shadow of the global and base enables
  logic [7:0] xen_sh;  // Shadow of the extended enables
  wire        wr_ok  = psel_i && penable_i && pwrite_i && pready_o && pstrb_i[0];  // Write lands
  wire        masked = !en_sh[7] || en_sh[6];  // Global gate closed

  default clocking dcb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Track enable writes as they complete
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_sh  <= 8'h00;
      xen_sh <= 8'h00;
    end else if (wr_ok && paddr_i == PIPC_ADDR_IRQ_EN) begin
      en_sh  <= pwdata_i[7:0];
    end else if (wr_ok && paddr_i == PIPC_ADDR_EXT_EN) begin
      xen_sh <= pwdata_i[7:0];
    end
  end

  a_vec_match: assert property (irq_req_o |-> irq_vector_o == 16'h0003 + {irq_num_o, 3'h0})
    else $error("offered vector does not match number");
  a_num_range: assert property (irq_req_o |-> irq_num_o <= 4'hd)
    else $error("offered number out of range");
  a_global_mask: assert property (masked && $past(masked) |-> !irq_req_o)
    else $error("request while globally masked");
  a_pin_gate: assert property (!xen_sh[6] && $past(!xen_sh[6])
    |-> !(irq_req_o && irq_num_o == PIPC_PIN_IRQ_NO))
    else $error("pin request without master enable");
  a_ack_drops: assert property (irq_ack_i && irq_req_o |=> !irq_req_o)
    else $error("request stays after entry");
  a_wdog_low: assert property (irq_req_o && irq_num_o == 4'hd |-> !irq_high_o)
    else $error("watchdog offered as high class");
  a_run_code: assert property (pready_o && !pwrite_i && paddr_i == PIPC_ADDR_BASE_PRI
    |-> prdata_o[7:6] != 2'b11)
    else $error("running flags read as both set");
  a_ready_answer: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("ready not a single cycle after setup");
  a_unmapped_err: assert property (pready_o && paddr_i > PIPC_ADDR_STATUS |-> pslverr_o)
    else $error("unmapped access without error");
  a_rdata_upper: assert property (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule

// ==== bench/pipc_core_model.sv ====
// Behavioural core entry and return sequencer facing the controller
`timescale 1ns/100ps
module pipc_core_model (
  input  wire logic       ref_clk_i,   // System clock
  input  wire logic       rst_n_i,     // Reset, active low
  input  wire logic       irq_req_i,   // Request from controller
  input  wire logic       ack_en_i,    // Bench lets the core take requests
  input  wire logic [2:0] ack_wait_i,  // Cycles to linger before entry
  input  wire logic       ret_go_i,    // Bench asks for a return
  output logic            irq_ack_o,   // Entry pulse
  output logic            irq_ret_o    // Return pulse
);
  logic [2:0] wait_r;  // Cycles the request has waited
  // Entry only while a request stands, so a withdrawn one is never taken
  assign irq_ack_o = irq_req_i && ack_en_i && (wait_r == ack_wait_i);
  // Wait counter and registered return pulse
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_r    <= 3'h0;
      irq_ret_o <= 1'b0;
    end else begin
      irq_ret_o <= ret_go_i;
      wait_r    <= (irq_req_i && !irq_ack_o) ? wait_r + 3'h1 : 3'h0;
    end
  end
endmodule

// ==== bench/pipc_ctrl_test.sv ====
// Self-checking bench for the pin interrupt and priority controller
`timescale 1ns/100ps
module pipc_ctrl_test;
  import pipc_pkg::*;
  localparam logic [6:0] PIN_IDLE = 7'h7b;  // Reset pin idles low, others high
  int          err_total, n_compared, cyc, seed, b;
  logic [7:0]  paddr, bp, ep, ie, xe;
  logic [31:0] pwdata, prdata, rd_v;
  logic [13:0] src_req, rq, hi;
  logic [15:0] vec;
  logic [6:0]  pin;
  logic [4:0]  p;
  logic [3:0]  num, pstrb;
  logic [2:0]  ack_wait;
  logic [1:0]  pin_b;
  logic        ref_clk, rst_n, psel, penable, pwrite, ack_en, ret_go, ce;
  logic        pready, pslverr, err_v, req, high, ack, ret;

  pipc_ctrl i_pipc_ctrl (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .ser1_rx_a_i(pin[6]), .ser1_rx_b_i(pin_b[1]), .port1_pin5_i(pin[5]),
    .port1_pin4_i(pin[4]), .port1_pin3_i(pin[3]), .reset_pin_i(pin[2]),
    .port3_pin1_i(pin[1]), .ser0_rx_a_i(pin[0]), .ser0_rx_b_i(pin_b[0]),
    .src_req_i(src_req), .irq_ack_i(ack), .irq_ret_i(ret), .irq_req_o(req),
    .irq_num_o(num), .irq_vector_o(vec), .irq_high_o(high));
  pipc_core_model i_pipc_core_model (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .irq_req_i(req),
    .ack_en_i(ack_en), .ack_wait_i(ack_wait), .ret_go_i(ret_go), .irq_ack_o(ack),
    .irq_ret_o(ret));

  // Expected winner: high class first, then lowest number
  function automatic logic [4:0] pick(input logic [13:0] r, input logic [13:0] h);
    logic [4:0] w;
    w = 5'h00;
    for (int i = 13; i >= 0; i--) begin
      if (r[i] && !h[i]) w = {1'b0, 4'(i)};
    end
    for (int i = 13; i >= 0; i--) begin
      if (r[i] && h[i]) w = {1'b1, 4'(i)};
    end
    return w;
  endfunction

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd_v  = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pulse a return through the core model
  task automatic do_ret();
    ret_go <= 1'b1;
    @(posedge ref_clk);
    ret_go <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  // Verdict and end of run
  task automatic results();
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  // Main sequence
  initial begin
    {psel, penable, pwrite, ack_en, ret_go, rst_n} = 6'h00;
    {paddr, pwdata, src_req, ack_wait} = '0;
    {err_total, n_compared, cyc} = '0;
    pin = PIN_IDLE;
    pin_b = 2'h3;
    pstrb = 4'hf;
    ce = 1'b1;
    seed = 32'h8420beaf;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Reset values and an unmapped address
    for (int a = 0; a < 8; a++) begin
      apb(1'b0, 8'(a * 4), 8'h00);
      chk(rd_v, 32'h0);
      chk({31'h0, err_v}, {31'h0, a == 7});
    end
    // Random priorities, enables and requests
    for (int k = 0; k < 20; k++) begin
      bp = 8'($random(seed));
      ep = 8'($random(seed));
      ie = 8'($random(seed));
      xe = 8'($random(seed)) & 8'hbf;
      apb(1'b1, PIPC_ADDR_BASE_PRI, bp);
      apb(1'b1, PIPC_ADDR_EXT_PRI, ep);
      apb(1'b1, PIPC_ADDR_IRQ_EN, ie);
      apb(1'b1, PIPC_ADDR_EXT_EN, xe);
      src_req <= 14'($random(seed));
      repeat (3) @(posedge ref_clk);
      rq = src_req & {xe, ie[5:0]} & 14'h2fff;
      hi = {1'b0, ep[6:0], bp[5:0]};
      p  = pick(rq, hi);
      chk({31'h0, req}, {31'h0, ie[7] & ~ie[6] & (|rq)});
      if (req === 1'b1) chk({11'h0, high, num, vec}, {11'h0, p, 16'h0003 + {9'h0, p[3:0], 3'h0}});
      apb(1'b0, PIPC_ADDR_BASE_PRI, 8'h00);
      chk(rd_v, {26'h0, bp[5:0]});
      apb(1'b0, PIPC_ADDR_EXT_PRI, 8'h00);
      chk(rd_v, {25'h0, ep[6:0]});
    end
    // Level mode, each pin source alone
    apb(1'b1, PIPC_ADDR_IRQ_EN, 8'h80);
    apb(1'b1, PIPC_ADDR_EXT_EN, 8'h40);
    src_req <= 14'h0;
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, PIPC_ADDR_PIN_EN, 8'(1 << i));
      pin <= PIN_IDLE ^ 7'(1 << i);
      repeat (4) @(posedge ref_clk);
      chk({27'h0, req, num}, {27'h0, 1'b1, PIPC_PIN_IRQ_NO});
      apb(1'b0, PIPC_ADDR_STATUS, 8'h00);
      chk(rd_v, 32'h1);
      pin <= PIN_IDLE;
      repeat (4) @(posedge ref_clk);
      apb(1'b0, PIPC_ADDR_STATUS, 8'h00);
      chk(rd_v, 32'h0);
    end
    // Edge mode: flag sticks, ignores software, clears on entry
    apb(1'b1, PIPC_ADDR_PIN_EN, 8'h88);
    pin[3] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    pin[3] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, PIPC_ADDR_STATUS, 8'h00);
    chk(rd_v, 32'h1);
    apb(1'b1, PIPC_ADDR_STATUS, 8'h00);
    apb(1'b0, PIPC_ADDR_STATUS, 8'h00);
    chk(rd_v, 32'h1);
    ack_en <= 1'b1;
    repeat (12) @(posedge ref_clk);
    ack_en <= 1'b0;
    apb(1'b0, PIPC_ADDR_STATUS, 8'h00);
    chk(rd_v, 32'h0);
    do_ret();
    // Low routine preempted by a high one, then unwound
    apb(1'b1, PIPC_ADDR_EXT_EN, 8'h00);
    apb(1'b1, PIPC_ADDR_IRQ_EN, 8'h89);
    apb(1'b1, PIPC_ADDR_BASE_PRI, 8'h01);
    ack_wait <= 3'($random(seed));
    ack_en   <= 1'b1;
    src_req  <= 14'h0008;
    repeat (14) @(posedge ref_clk);
    apb(1'b0, PIPC_ADDR_BASE_PRI, 8'h00);
    chk(rd_v, 32'h41);
    apb(1'b0, PIPC_ADDR_EXT_PRI, 8'h00);
    chk(rd_v, {24'h0, 1'b1, ep[6:0]});
    src_req <= 14'h0009;
    repeat (14) @(posedge ref_clk);
    ack_en  <= 1'b0;
    src_req <= 14'h0;
    apb(1'b0, PIPC_ADDR_BASE_PRI, 8'h00);
    chk(rd_v, 32'h81);
    apb(1'b0, PIPC_ADDR_EXT_PRI, 8'h00);
    chk(rd_v, {25'h0, ep[6:0]});
    do_ret();
    apb(1'b0, PIPC_ADDR_BASE_PRI, 8'h00);
    chk(rd_v, 32'h41);
    do_ret();
    apb(1'b0, PIPC_ADDR_BASE_PRI, 8'h00);
    chk(rd_v, 32'h01);
    // Alternate serial mapping; a write without the low strobe is refused
    apb(1'b1, PIPC_ADDR_REMAP, 8'h03);
    pstrb <= 4'he;
    apb(1'b1, PIPC_ADDR_REMAP, 8'h00);
    pstrb <= 4'hf;
    apb(1'b0, PIPC_ADDR_REMAP, 8'h00);
    chk(rd_v, 32'h3);
    apb(1'b1, PIPC_ADDR_EXT_EN, 8'h40);
    // Edge mode on serial 0, reset pin and serial 1, cleared by level mode
    for (int j = 0; j < 3; j++) begin
      b = j * (j + 1);
      apb(1'b1, PIPC_ADDR_PIN_EN, 8'h80 | 8'(1 << b));
      if (b != 2) pin <= PIN_IDLE ^ 7'(1 << b);
      repeat (3) @(posedge ref_clk);
      pin <= PIN_IDLE;
      apb(1'b0, PIPC_ADDR_STATUS, 8'h00);
      chk(rd_v, 32'h0);
      if (b == 2) pin <= PIN_IDLE ^ 7'h04;
      else pin_b <= 2'h3 ^ 2'(1 << (b / 6));
      @(posedge ref_clk);
      pin <= PIN_IDLE;
      pin_b <= 2'h3;
      repeat (3) @(posedge ref_clk);
      apb(1'b0, PIPC_ADDR_STATUS, 8'h00);
      chk(rd_v, 32'h1);
      apb(1'b1, PIPC_ADDR_PIN_EN, 8'h00);
      apb(1'b0, PIPC_ADDR_STATUS, 8'h00);
      chk(rd_v, 32'h0);
    end
    // Frozen clock enable lets a pin pulse pass unseen
    apb(1'b1, PIPC_ADDR_PIN_EN, 8'h88);
    ce <= 1'b0;
    pin[3] <= 1'b0;
    repeat (3) @(posedge ref_clk);
    pin[3] <= 1'b1;
    @(posedge ref_clk);
    ce <= 1'b1;
    apb(1'b0, PIPC_ADDR_STATUS, 8'h00);
    chk(rd_v, 32'h0);
    // Reset in mid-run returns the registers to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, PIPC_ADDR_PIN_EN, 8'h00);
    chk(rd_v, 32'h0);
    apb(1'b0, PIPC_ADDR_REMAP, 8'h00);
    chk(rd_v, 32'h0);
    results();
  end
endmodule

bind pipc_ctrl pipc_asserts i_pipc_asserts (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o),
  .irq_num_o(irq_num_o), .irq_vector_o(irq_vector_o), .irq_high_o(irq_high_o));
